// ---- hdl/framer_global_pkg.sv ----
// Purpose: Shared constants for the framer global control block.
// Assumes: 25 MHz system clock; 12-bit processor address.
// Notes:   Framer selector lives in the top four address bits.
package framer_global_pkg;

    // ****************************************************************
    // Sizes
    // ****************************************************************
    localparam int NUM_FRAMERS   = 8;
    localparam int ADDR_WIDTH    = 12;
    localparam int DATA_WIDTH    = 16;
    localparam int SEL_MSB       = 11;
    localparam int SEL_LSB       = 8;

    // ****************************************************************
    // Selector codes and bit positions
    // ****************************************************************
    localparam logic [3:0] SEL_ALL_FRAMERS = 4'h8;
    localparam int SEL_TOP_BIT   = 3;
    localparam int SEL_MID_BIT   = 1;
    localparam int SEL_LOW_BIT   = 0;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 40;
    localparam int RESET_MIN_NS  = 100;
    localparam int RESET_MIN_CYCLES =
        (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0] RST_ENABLE_MASK = 8'h00;
    localparam logic [7:0] RST_E1_MODE     = 8'h00;

    // ****************************************************************
    // Global register offsets within the global page
    // ****************************************************************
    localparam logic [7:0] REG_T1_ENABLE  = 8'h00;
    localparam logic [7:0] REG_E1_ENABLE  = 8'h01;
    localparam logic [7:0] REG_LINE_MODE  = 8'h02;
    localparam logic [7:0] REG_STATUS     = 8'h03;

endpackage : framer_global_pkg

// ---- hdl/pulse_edge_sync.sv ----
// Purpose: Three-stage synchroniser with falling-edge detection.
// Assumes: Input is asynchronous to clk.
// Notes:   First stage is read only by the second stage.
`timescale 1ns/1ps
module pulse_edge_sync #(
    // Level the chain holds in reset; pick the pin's safe level.
    parameter logic RESET_LEVEL = 1'b1
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Pin
    input  wire logic async_in,
    // Results
    output logic      level,
    output logic      fall
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic fall;
    } state_t;

    state_t cur;
    state_t next_cur;

    always_comb begin
        next_cur      = cur;
        next_cur.s1   = async_in;
        next_cur.s2   = cur.s1;
        next_cur.s3   = cur.s2;
        next_cur.fall = cur.s3 & ~cur.s2;
        if (rst) begin
            next_cur = '{s1: RESET_LEVEL, s2: RESET_LEVEL,
                         s3: RESET_LEVEL, fall: 1'b0};
        end
    end

    always_ff @(posedge clk) begin
        cur <= next_cur;
    end

    assign level = cur.s3;
    assign fall  = cur.fall;

endmodule : pulse_edge_sync

// ---- hdl/framer_global_control.sv ----
// Purpose: Global reset, alarm force, multiframe pulse and address decode
//          shared by eight framers.
// Assumes: The three device pins are asynchronous and pass three flip-flops first.
// Notes:   Function
`timescale 1ns/1ps
module framer_global_control #(
    parameter int NUM_FRAMERS = framer_global_pkg::NUM_FRAMERS
) (
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       rst,
    // Device pins
    input  wire logic                       global_reset_n,
    input  wire logic                       force_line_alarm_all_ones_n,
    input  wire logic                       tx_multiframe_boundary_pulse,
    // Processor port
    input  wire logic [framer_global_pkg::ADDR_WIDTH-1:0] addr,
    input  wire logic [framer_global_pkg::DATA_WIDTH-1:0] wdata,
    input  wire logic                       wr,
    input  wire logic                       rd,
    output logic [framer_global_pkg::DATA_WIDTH-1:0]      rdata,
    // Framer side
    output logic [NUM_FRAMERS-1:0]          framer_reset,
    output logic                            line_alarm_all_ones,
    output logic [NUM_FRAMERS-1:0]          framer_wr,
    output logic [NUM_FRAMERS-1:0]          framer_rd,
    output logic [framer_global_pkg::ADDR_WIDTH-1:0]      framer_addr,
    output logic [framer_global_pkg::DATA_WIDTH-1:0]      framer_wdata,
    output logic [NUM_FRAMERS-1:0]          tx_frame0_mark,
    output logic [NUM_FRAMERS-1:0]          internal_boundary
);

    // ****************************************************************
    // Selector decode
    // ****************************************************************
    typedef enum logic [1:0] {SEL_ONE, SEL_ALL, SEL_GLOBAL, SEL_NONE}
        sel_kind_t;

    function automatic sel_kind_t decode_sel(input logic [3:0] sel);
        if (!sel[framer_global_pkg::SEL_TOP_BIT]) begin
            decode_sel = SEL_ONE;
        end else if (sel == framer_global_pkg::SEL_ALL_FRAMERS) begin
            decode_sel = SEL_ALL;
        end else if (sel[framer_global_pkg::SEL_LOW_BIT] &&
                     !sel[framer_global_pkg::SEL_MID_BIT]) begin
            decode_sel = SEL_GLOBAL;
        end else begin
            decode_sel = SEL_NONE;
        end
    endfunction : decode_sel

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic reset_n_level;
    logic alarm_n_level;
    logic mf_level;
    logic mf_fall;

    // The reset chain clears to the asserted level, so a pin still held
    // low cannot let the framers out of reset while the chain refills.
    pulse_edge_sync #(
        .RESET_LEVEL (1'b0)
    ) u_reset_sync (
        .clk      (clk),
        .rst      (rst),
        .async_in (global_reset_n),
        .level    (reset_n_level),
        .fall     ()
    );

    pulse_edge_sync u_alarm_sync (
        .clk      (clk),
        .rst      (rst),
        .async_in (force_line_alarm_all_ones_n),
        .level    (alarm_n_level),
        .fall     ()
    );

    // The pulse is sampled on the backplane-timed system clock.
    pulse_edge_sync u_mf_sync (
        .clk      (clk),
        .rst      (rst),
        .async_in (tx_multiframe_boundary_pulse),
        .level    (mf_level),
        .fall     (mf_fall)
    );

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [NUM_FRAMERS-1:0] t1_external_superframe_enable;
        logic [NUM_FRAMERS-1:0] e1_external_multiframe_enable;
        logic [NUM_FRAMERS-1:0] e1_mode;
        logic [NUM_FRAMERS-1:0] framer_reset;
        logic                   alarm;
        logic [NUM_FRAMERS-1:0] framer_wr;
        logic [NUM_FRAMERS-1:0] framer_rd;
        logic [framer_global_pkg::ADDR_WIDTH-1:0] framer_addr;
        logic [framer_global_pkg::DATA_WIDTH-1:0] framer_wdata;
        logic [framer_global_pkg::DATA_WIDTH-1:0] rdata;
        logic [NUM_FRAMERS-1:0] frame0_mark;
        logic [NUM_FRAMERS-1:0] internal_boundary;
    } state_t;

    state_t cur;
    state_t next_cur;

    logic [3:0]             sel;
    logic [2:0]             idx;
    logic [7:0]             reg_off;
    sel_kind_t              kind;
    logic [NUM_FRAMERS-1:0] ext_en;

    assign sel     = addr[framer_global_pkg::SEL_MSB:framer_global_pkg::SEL_LSB];
    assign idx     = sel[2:0];
    assign reg_off = addr[7:0];
    assign kind    = decode_sel(sel);

    always_comb begin
        next_cur              = cur;
        next_cur.framer_wr    = '0;
        next_cur.framer_rd    = '0;
        next_cur.rdata        = '0;
        next_cur.framer_addr  = addr;
        next_cur.framer_wdata = wdata;

        // Global reset pin holds every framer and register at default.
        next_cur.framer_reset = {NUM_FRAMERS{~reset_n_level}};

        // The force pin bypasses all register state.
        next_cur.alarm = ~alarm_n_level;

        // Each framer picks T1 or E1 enable by its own e1_mode line-rate bit.
        ext_en = (cur.t1_external_superframe_enable & ~cur.e1_mode) |
                 (cur.e1_external_multiframe_enable & cur.e1_mode);
        next_cur.frame0_mark       = ext_en & {NUM_FRAMERS{mf_fall}};
        // A pin held high, or no enable, leaves the framer free running.
        next_cur.internal_boundary = ~ext_en |
                                     {NUM_FRAMERS{mf_level}};

        if (wr) begin
            unique case (kind)
                SEL_ONE:    next_cur.framer_wr[idx] = 1'b1;
                SEL_ALL:    next_cur.framer_wr = '1;
                SEL_GLOBAL: begin
                    if (reg_off == framer_global_pkg::REG_T1_ENABLE) begin
                        next_cur.t1_external_superframe_enable = wdata[7:0];
                    end
                    if (reg_off == framer_global_pkg::REG_E1_ENABLE) begin
                        next_cur.e1_external_multiframe_enable = wdata[7:0];
                    end
                    if (reg_off == framer_global_pkg::REG_LINE_MODE) begin
                        next_cur.e1_mode = wdata[7:0];
                    end
                end
                SEL_NONE:   ;
            endcase
        end else if (rd) begin
            unique case (kind)
                SEL_ONE:    next_cur.framer_rd[idx] = 1'b1;
                // Broadcast reads are refused and return zero.
                SEL_ALL:    ;
                SEL_GLOBAL: begin
                    unique case (reg_off)
                        framer_global_pkg::REG_T1_ENABLE:
                            next_cur.rdata = {8'h00,
                                cur.t1_external_superframe_enable};
                        framer_global_pkg::REG_E1_ENABLE:
                            next_cur.rdata = {8'h00,
                                cur.e1_external_multiframe_enable};
                        framer_global_pkg::REG_LINE_MODE:
                            next_cur.rdata = {8'h00, cur.e1_mode};
                        framer_global_pkg::REG_STATUS:
                            next_cur.rdata = {13'h0000, mf_level,
                                ~alarm_n_level, ~reset_n_level};
                        default: next_cur.rdata = '0;
                    endcase
                end
                SEL_NONE:   ;
            endcase
        end

        if (rst || !reset_n_level) begin
            next_cur.t1_external_superframe_enable =
                framer_global_pkg::RST_ENABLE_MASK;
            next_cur.e1_external_multiframe_enable =
                framer_global_pkg::RST_ENABLE_MASK;
            next_cur.e1_mode     = framer_global_pkg::RST_E1_MODE;
            next_cur.framer_wr   = '0;
            next_cur.framer_rd   = '0;
            next_cur.frame0_mark = '0;
        end
        if (rst) begin
            next_cur.framer_reset      = '1;
            next_cur.alarm             = 1'b0;
            next_cur.rdata             = '0;
            next_cur.framer_addr       = '0;
            next_cur.framer_wdata      = '0;
            next_cur.internal_boundary = '1;
        end
    end

    always_ff @(posedge clk) begin
        cur <= next_cur;
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign rdata               = cur.rdata;
    assign framer_reset        = cur.framer_reset;
    assign line_alarm_all_ones = cur.alarm;
    assign framer_wr           = cur.framer_wr;
    assign framer_rd           = cur.framer_rd;
    assign framer_addr         = cur.framer_addr;
    assign framer_wdata        = cur.framer_wdata;
    assign tx_frame0_mark      = cur.frame0_mark;
    assign internal_boundary   = cur.internal_boundary;

endmodule : framer_global_control

// ---- test/framer_global_checker_properties.sv ----
// Purpose: Port timing checks for the global control block.
// Assumes: Pins reach outputs three or four edges after they move.
// Notes:   Bound into every instance of the block.
`timescale 1ns/1ps
module framer_global_checker #(
    parameter int NUM_FRAMERS = 8
) (
    input wire logic                   clk,
    input wire logic                   rst,
    input wire logic                   global_reset_n,
    input wire logic                   force_line_alarm_all_ones_n,
    input wire logic                   tx_multiframe_boundary_pulse,
    input wire logic [11:0]            addr,
    input wire logic                   wr,
    input wire logic                   rd,
    input wire logic [15:0]            rdata,
    input wire logic [NUM_FRAMERS-1:0] framer_reset,
    input wire logic                   line_alarm_all_ones,
    input wire logic [NUM_FRAMERS-1:0] framer_wr,
    input wire logic [NUM_FRAMERS-1:0] framer_rd,
    input wire logic [11:0]            framer_addr,
    input wire logic [NUM_FRAMERS-1:0] tx_frame0_mark,
    input wire logic [NUM_FRAMERS-1:0] internal_boundary
);
    // ****************************************************************
    // Properties
    // ****************************************************************
    logic [2:0] last_sel;
    always_ff @(posedge clk) last_sel <= addr[10:8];
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    AST_ALARM_ON: assert property (
        $fell(force_line_alarm_all_ones_n) |-> ##[3:4] line_alarm_all_ones)
        else $error("alarm did not start");
    AST_ALARM_OFF: assert property (
        $rose(force_line_alarm_all_ones_n) |-> ##[3:4] !line_alarm_all_ones)
        else $error("alarm did not stop");
    AST_RST_ON: assert property (
        $fell(global_reset_n) |-> ##[3:4] framer_reset == '1)
        else $error("framers not held in reset");
    AST_RST_OFF: assert property (
        $rose(global_reset_n) |-> ##[3:4] framer_reset == '0)
        else $error("framers not released");
    AST_WR_ROUTE: assert property (
        wr && !addr[11] && framer_reset == '0 |=> framer_addr == $past(addr)
        && framer_wr == (NUM_FRAMERS'(1) << last_sel))
        else $error("framer write misrouted");
    AST_BCAST_WR: assert property (
        wr && addr[11:8] == 4'h8 && framer_reset == '0 |=> framer_wr == '1)
        else $error("broadcast write missed");
    AST_BCAST_RD: assert property (
        rd && addr[11:8] == 4'h8 |=> framer_rd == '0 && rdata == 16'h0000)
        else $error("broadcast read not refused");
    AST_GLOBAL: assert property (
        (wr || rd) && addr[11] && !addr[9] && addr[8]
        |=> framer_wr == '0 && framer_rd == '0)
        else $error("global access reached a framer");
    AST_MARK_ONE: assert property (
        tx_frame0_mark != '0 |=> tx_frame0_mark == '0)
        else $error("mark longer than one cycle");
    AST_MARK_IDLE: assert property (
        tx_multiframe_boundary_pulse [*8] |-> tx_frame0_mark == '0)
        else $error("mark without pulse");
    AST_MARK_EXT: assert property (
        tx_frame0_mark != '0 |-> (tx_frame0_mark & internal_boundary) == '0)
        else $error("mark on internally timed framer");
    COV_MARK: cover property (tx_frame0_mark != '0);
    COV_BCAST: cover property (framer_wr == '1);
    COV_ALARM: cover property ($rose(line_alarm_all_ones));
endmodule : framer_global_checker
bind framer_global_control framer_global_checker #(
    .NUM_FRAMERS(NUM_FRAMERS)) checker_i (.*);

// ---- test/backplane_model.sv ----
// Purpose: Backplane timing and board reset in front of the block.
// Assumes: Frame pulse idles high and falls once per request.
// Notes:   Reset is stretched so it always lasts at least 120 ns.
`timescale 1ns/1ps
module backplane_model (
    input  wire logic clk,
    input  wire logic fire,
    input  wire logic hold,
    output logic      mf_pulse,
    output logic      reset_n
);
    logic [1:0] low_cnt;
    logic [1:0] stretch;
    initial begin
        low_cnt = 2'h0;
        stretch = 2'h3;
    end
    always @(posedge clk) begin
        if (fire)
            low_cnt <= 2'h3;
        else if (low_cnt != 2'h0)
            low_cnt <= low_cnt - 2'h1;
        if (hold)
            stretch <= 2'h3;
        else if (stretch != 2'h0)
            stretch <= stretch - 2'h1;
    end
    assign mf_pulse = (low_cnt == 2'h0);
    assign reset_n  = (stretch == 2'h0);
endmodule : backplane_model

// ---- test/framer_global_control_tb.sv ----
// Purpose: Directed tests of the global control block.
// Assumes: Outputs settle one nanosecond after the clock edge.
// Notes:   Register accesses leave one idle cycle between them.
`timescale 1ns/1ps
module framer_global_control_tb;
    logic        clk, rst, fire, hold, alarm_n, wr, rd, rst_n, mf, alarm;
    logic [11:0] addr, f_addr;
    logic [15:0] wdata, rdata, got, f_wdata;
    logic [7:0]  f_rst, f_wr, f_rd, mark, ib;
    int          err_total, tests_run;
    backplane_model bp (.clk(clk), .fire(fire), .hold(hold),
        .mf_pulse(mf), .reset_n(rst_n));
    framer_global_control dut (.clk(clk), .rst(rst),
        .global_reset_n(rst_n), .force_line_alarm_all_ones_n(alarm_n),
        .tx_multiframe_boundary_pulse(mf), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .framer_reset(f_rst),
        .line_alarm_all_ones(alarm), .framer_wr(f_wr), .framer_rd(f_rd),
        .framer_addr(f_addr), .framer_wdata(f_wdata),
        .tx_frame0_mark(mark), .internal_boundary(ib));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic wr_reg(input logic [11:0] a, input logic [15:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask : wr_reg
    task automatic rd_reg(input logic [11:0] a);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 got = rdata;
    endtask : rd_reg
    task automatic summarize();
        $display("errors %0d of %0d checks", err_total, tests_run);
        if (err_total == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : summarize
    initial begin
        #100000;
        err_total++;
        summarize();
    end
    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        {rst, hold, fire, alarm_n, wr, rd} = 6'b110100;
        addr  = 12'h000;
        wdata = 16'h0000;
        tick(6);
        rst <= 1'b0;
        tick(1);
        chk({8'h00, f_rst}, 16'h00FF);
        tick(3);
        chk({8'h00, f_rst}, 16'h00FF);
        hold <= 1'b0;
        tick(10);
        chk({8'h00, f_rst}, 16'h0000);
        wr_reg(12'h900, 16'h0005);
        wr_reg(12'hD01, 16'h0032);
        wr_reg(12'h902, 16'h00F0);
        chk({8'h00, f_wr}, 16'h0000);
        rd_reg(12'hD00);
        chk(got, 16'h0005);
        rd_reg(12'h903);
        chk(got, 16'h0004);
        rd_reg(12'h9FF);
        chk(got, 16'h0000);
        chk({8'h00, ib}, 16'h00FF);
        fire <= 1'b1;
        tick(1);
        fire <= 1'b0;
        for (int i = 0; i < 12 && mark == 8'h00; i++)
            tick(1);
        chk({8'h00, mark}, 16'h0035);
        for (int s = 0; s < 8; s++) begin
            wr_reg({4'(s), 8'h10}, 16'hA500 + 16'(s));
            chk({8'h00, f_wr}, 16'h0001 << s);
            chk(f_wdata, 16'hA500 + 16'(s));
        end
        wr_reg(12'h840, 16'h1234);
        chk({8'h00, f_wr}, 16'h00FF);
        rd_reg(12'h840);
        chk(got, 16'h0000);
        chk({8'h00, f_rd}, 16'h0000);
        rd_reg(12'h340);
        chk({8'h00, f_rd}, 16'h0008);
        alarm_n <= 1'b0;
        tick(6);
        chk({15'h0000, alarm}, 16'h0001);
        rd_reg(12'h903);
        chk(got, 16'h0006);
        alarm_n <= 1'b1;
        tick(6);
        chk({15'h0000, alarm}, 16'h0000);
        hold <= 1'b1;
        tick(6);
        chk({8'h00, f_rst}, 16'h00FF);
        wr_reg(12'h900, 16'h00FF);
        hold <= 1'b0;
        tick(10);
        rd_reg(12'h900);
        chk(got, 16'h0000);
        summarize();
    end
endmodule : framer_global_control_tb
